// ### dlc_pkg.sv
// Shared types and constants of the directed link change and hot reset block.
// Assumes a single 250 MHz user clock shared with the link training engine.
package dlc_pkg;

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] CHG_NONE = 2'h0;
  localparam logic [1:0] CHG_WIDTH = 2'h1;
  localparam logic [1:0] CHG_SPEED = 2'h2;
  localparam logic [1:0] CHG_BOTH = 2'h3;

  localparam logic SPEED_2G5 = 1'b0;
  localparam logic SPEED_5G0 = 1'b1;

  localparam logic [1:0] LANES_X1 = 2'h0;
  localparam logic [1:0] LANES_X2 = 2'h1;
  localparam logic [1:0] LANES_X4 = 2'h2;
  localparam logic [1:0] LANES_X8 = 2'h3;

  localparam logic DEEMPH_6DB = 1'b0;
  localparam logic DEEMPH_3P5DB = 1'b1;

  localparam logic DSRC_PARTNER = 1'b0;
  localparam logic DSRC_LINKCTL2 = 1'b1;

  localparam logic [1:0] AUTO_SPEED_ENABLED = 2'h3;

  localparam int unsigned LTS_W = 6;
  localparam logic [LTS_W-1:0] LTS_HOT_RESET = 6'h21;
  localparam logic [LTS_W-1:0] LTS_RESET_VAL = 6'h00;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  // Directed change request from the user logic
  typedef struct packed {
    logic [1:0] code;
    logic speed;
    logic [1:0] lanes;
    logic autonomous;
  } dlc_req_t;

  // Command handed to the link training engine
  typedef struct packed {
    logic valid;
    logic do_width;
    logic do_speed;
    logic speed;
    logic [1:0] lanes;
    logic autonomous;
  } dlc_cmd_t;

  // Status reported by the link training engine
  typedef struct packed {
    logic link_up;
    logic gen2_capable;
    logic [LTS_W-1:0] state;
    logic cmd_accept;
    logic change_done;
  } dlc_eng_t;

  localparam dlc_cmd_t CMD_IDLE = '{default: 1'b0};

endpackage

// ### dlc_link_ctrl.sv
// User-side physical layer control: directed width/speed change, 5.0 Gb/s
// de-emphasis selection and role-specific hot reset handling.
// Assumes the link training engine and the user logic share clk.
//
// What this block does
// (RULE1) User logic asks for none, width, speed or both by a two-bit code while link is up.
// (RULE2) Target speed low is 2.5 Gb/s, high is 5.0 Gb/s, high only if second gen capable.
// (RULE3) As root port, speed or combined changes need the auto speed attribute at 11.
// (RULE4) A reason bit goes with each change: low for reliability, high for autonomous need.
// (RULE5) Target lane count codes 00, 01, 10, 11 mean one, two, four and eight lanes.
// (RULE6) The block raises a completion output once a directed width or speed change is done.
// (RULE7) As endpoint, the de-emphasis preference sets the de-emphasis requested at 5.0 Gb/s.
// (RULE8) De-emphasis preference low selects -6 dB and high selects -3.5 dB.
// (RULE9) User logic may move the de-emphasis preference along with a 2.5 to 5.0 Gb/s request.
// (RULE10) As endpoint, the block raises hot-reset-received when an in-band hot reset arrives.
// (RULE11) As root port, user logic holds the hot reset send input until the state reads 6'h21.
// (RULE12) After the hot reset state is reached the send input may drop and the link retrains.
// (RULE13) As root port, source low takes partner de-emphasis and high takes link control 2.
// (RULE14) User logic returns the code to no-change after completion, before the next change.
module dlc_link_ctrl #(
  parameter logic [1:0] ROOTPORT_AUTO_SPEED_ATTR = 2'h0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Role strap, static after reset: high for root port
  input wire logic role_rootport,
  // User directed change request
  input wire logic [1:0] change_request_code,
  input wire logic target_speed_select,
  input wire logic [1:0] target_lane_count,
  input wire logic change_reason_autonomous,
  output logic change_complete,
  // User de-emphasis and hot reset controls
  input wire logic endpoint_deemphasis_pref,
  input wire logic rootport_deemphasis_source,
  input wire logic inband_reset_send,
  output logic inband_reset_received,
  // User status
  output logic link_up,
  output logic second_gen_capable,
  output logic [dlc_pkg::LTS_W-1:0] link_training_state,
  // Link training engine side
  input wire dlc_pkg::dlc_eng_t eng_status,
  input wire logic partner_deemph,
  input wire logic linkctl2_deemph,
  output dlc_pkg::dlc_cmd_t eng_cmd,
  output logic eng_tx_deemph,
  output logic eng_hot_reset_tx
);

  // ----------------------------------------------------------------------
  // Role capture
  // ----------------------------------------------------------------------
  // The strap is caught by the first clocked edge after release, never by
  // the reset itself.
  logic role_seen_q;
  logic rootport_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      role_seen_q <= 1'b0;
      rootport_q <= 1'b0;
    end else if (!role_seen_q) begin
      role_seen_q <= 1'b1;
      rootport_q <= role_rootport;
    end
  end

  // ----------------------------------------------------------------------
  // Status mirror
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      link_up <= 1'b0;
      second_gen_capable <= 1'b0;
      link_training_state <= dlc_pkg::LTS_RESET_VAL;
    end else begin
      link_up <= eng_status.link_up;
      second_gen_capable <= eng_status.gen2_capable;
      link_training_state <= eng_status.state;
    end
  end

  // ----------------------------------------------------------------------
  // Request qualification
  // ----------------------------------------------------------------------
  dlc_pkg::dlc_req_t req;
  logic want_width;
  logic want_speed;
  logic speed_allowed;
  logic req_ok;

  assign req = '{code: change_request_code, speed: target_speed_select,
                 lanes: target_lane_count, autonomous: change_reason_autonomous};
  assign want_width = req.code == dlc_pkg::CHG_WIDTH || req.code == dlc_pkg::CHG_BOTH;
  assign want_speed = req.code == dlc_pkg::CHG_SPEED || req.code == dlc_pkg::CHG_BOTH;

  // A speed move the port cannot make is dropped rather than sent to the
  // engine, which would otherwise sit in recovery with no way out.
  always_comb begin
    speed_allowed = 1'b1;
    if (want_speed && req.speed == dlc_pkg::SPEED_5G0 && !eng_status.gen2_capable) begin
      speed_allowed = 1'b0; // [RULE2]
    end
    if (want_speed && rootport_q &&
        ROOTPORT_AUTO_SPEED_ATTR != dlc_pkg::AUTO_SPEED_ENABLED) begin
      speed_allowed = 1'b0; // [RULE3]
    end
  end

  // Only taken while the link is up
  assign req_ok = role_seen_q && eng_status.link_up && req.code != dlc_pkg::CHG_NONE &&
                  speed_allowed; // [RULE1]

  // ----------------------------------------------------------------------
  // Directed change sequencer
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ISSUE,
    ST_WAIT,
    ST_DONE
  } dlc_state_t;

  dlc_state_t state_q;
  dlc_state_t state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (req_ok) begin
          state_d = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        if (!eng_status.link_up) begin
          state_d = ST_IDLE;
        end else if (eng_status.cmd_accept) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (eng_status.change_done) begin
          state_d = ST_DONE;
        end else if (!eng_status.link_up) begin
          state_d = ST_IDLE;
        end
      end
      ST_DONE: begin
        // Held until the user withdraws the code, so one request yields one change
        if (change_request_code == dlc_pkg::CHG_NONE) begin
          state_d = ST_IDLE; // [RULE14]
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Command latched when a qualified request is taken in idle; valid held until the engine accepts it or the link drops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      eng_cmd <= dlc_pkg::CMD_IDLE;
    end else if (state_q == ST_IDLE && req_ok) begin
      eng_cmd.valid <= 1'b1;
      eng_cmd.do_width <= want_width;
      eng_cmd.do_speed <= want_speed;
      eng_cmd.speed <= req.speed; // [RULE2]
      eng_cmd.lanes <= req.lanes; // [RULE5]
      eng_cmd.autonomous <= req.autonomous; // [RULE4]
    end else if (state_d != ST_ISSUE) begin
      eng_cmd.valid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      change_complete <= 1'b0;
    end else begin
      change_complete <= state_d == ST_DONE; // [RULE6]
    end
  end

  // ----------------------------------------------------------------------
  // Transmitter de-emphasis at 5.0 Gb/s
  // ----------------------------------------------------------------------
  // Endpoint preference is sampled every cycle so it can move together with
  // a speed-up request; the engine reads it when it enters the new rate.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      eng_tx_deemph <= dlc_pkg::DEEMPH_6DB;
    end else if (!rootport_q) begin
      eng_tx_deemph <= endpoint_deemphasis_pref; // [RULE7] [RULE8] [RULE9]
    end else if (rootport_deemphasis_source == dlc_pkg::DSRC_LINKCTL2) begin
      eng_tx_deemph <= linkctl2_deemph; // [RULE13]
    end else begin
      eng_tx_deemph <= partner_deemph; // [RULE13]
    end
  end

  // ----------------------------------------------------------------------
  // Hot reset
  // ----------------------------------------------------------------------
  // Root port: forward the user's hold; retraining starts when it drops.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      eng_hot_reset_tx <= 1'b0;
    end else begin
      eng_hot_reset_tx <= rootport_q && inband_reset_send; // [RULE11] [RULE12]
    end
  end

  // Endpoint: report while the engine sits in the hot reset state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      inband_reset_received <= 1'b0;
    end else begin
      inband_reset_received <= role_seen_q && !rootport_q &&
                               eng_status.state == dlc_pkg::LTS_HOT_RESET; // [RULE10]
    end
  end

endmodule

// ### dlc_asserts.sv
// Concurrent checks on the ports of the link control block.
// Assumes it is bound to dlc_link_ctrl and sees only its ports.
module dlc_asserts #(
  parameter logic [1:0] ROOTPORT_AUTO_SPEED_ATTR = 2'h0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Observed ports
  input wire logic role_rootport,
  input wire logic [1:0] change_request_code,
  input wire logic [1:0] target_lane_count,
  input wire logic change_complete,
  input wire logic endpoint_deemphasis_pref,
  input wire logic rootport_deemphasis_source,
  input wire logic inband_reset_send,
  input wire logic inband_reset_received,
  input wire dlc_pkg::dlc_eng_t eng_status,
  input wire logic partner_deemph,
  input wire logic linkctl2_deemph,
  input wire dlc_pkg::dlc_cmd_t eng_cmd,
  input wire logic eng_tx_deemph,
  input wire logic eng_hot_reset_tx
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_cmd_fields: assert property ($rose(eng_cmd.valid) |-> $past(eng_status.link_up) &&
    eng_cmd.lanes == $past(target_lane_count) && eng_cmd.do_width == $past(change_request_code[0])
    && eng_cmd.do_speed == $past(change_request_code[1])) else $error("bad command fields");
  a_speed_gate: assert property ($rose(eng_cmd.valid) && eng_cmd.do_speed |->
    (!role_rootport || ROOTPORT_AUTO_SPEED_ATTR == 2'h3) &&
    (!eng_cmd.speed || $past(eng_status.gen2_capable))) else $error("speed change let through");
  a_valid_drop: assert property (eng_cmd.valid && eng_status.cmd_accept |=>
    !eng_cmd.valid) else $error("command held after accept");
  a_done_cause: assert property ($rose(change_complete) |->
    $past(eng_status.change_done)) else $error("completion without engine done");
  a_done_hold: assert property (change_complete && change_request_code != 2'h0 |=>
    change_complete) else $error("completion dropped early");
  a_done_clear: assert property (change_complete && change_request_code == 2'h0 |=>
    !change_complete) else $error("completion not cleared");
  // The role strap is only taken on the first edge after release, so the
  // role-dependent checks start one edge later.
  a_ep_deemph: assert property ($past(arst_n) && !role_rootport |=>
    eng_tx_deemph == $past(endpoint_deemphasis_pref)) else $error("endpoint deemphasis wrong");
  a_rp_deemph: assert property ($past(arst_n) && role_rootport |=> eng_tx_deemph ==
    ($past(rootport_deemphasis_source) ? $past(linkctl2_deemph) : $past(partner_deemph)))
    else $error("root port deemphasis wrong");
  a_hot_send: assert property ($past(arst_n) |=>
    eng_hot_reset_tx == $past(role_rootport && inband_reset_send)) else $error("hot tx");
  a_hot_recv: assert property ($past(arst_n) |=> inband_reset_received ==
    $past(!role_rootport && eng_status.state == dlc_pkg::LTS_HOT_RESET)) else $error("hot rx");
  c_issue: cover property ($rose(eng_cmd.valid));
  c_done: cover property ($rose(change_complete));
  c_hot: cover property ($rose(eng_hot_reset_tx));
endmodule

bind dlc_link_ctrl dlc_asserts #(.ROOTPORT_AUTO_SPEED_ATTR(ROOTPORT_AUTO_SPEED_ATTR)) u_chk (
  .clk, .arst_n, .role_rootport, .change_request_code, .target_lane_count, .change_complete,
  .endpoint_deemphasis_pref, .rootport_deemphasis_source, .inband_reset_send,
  .inband_reset_received, .eng_status, .partner_deemph, .linkctl2_deemph, .eng_cmd,
  .eng_tx_deemph, .eng_hot_reset_tx);

// ### dlc_eng_model.sv
// Behavioural link training engine answering directed change commands.
// Assumes the bench supplies link, capability and state levels.
module dlc_eng_model (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Command and bench levels
  input wire dlc_pkg::dlc_cmd_t eng_cmd,
  input wire logic link_up,
  input wire logic gen2,
  input wire logic slow,
  input wire logic [dlc_pkg::LTS_W-1:0] state,
  // Status back to the block
  output dlc_pkg::dlc_eng_t eng_status
);
  logic [4:0] cnt_q;
  logic busy_q;
  logic acc_q;
  logic done_q;
  // Pulses last one cycle; a link drop forgets the command like real training
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 5'h00;
      busy_q <= 1'b0;
      acc_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      acc_q <= 1'b0;
      done_q <= 1'b0;
      if (!link_up) begin
        busy_q <= 1'b0;
        cnt_q <= 5'h00;
      end else if (busy_q) begin
        if (cnt_q == 5'h00) begin
          done_q <= 1'b1;
          busy_q <= 1'b0;
        end else cnt_q <= cnt_q - 5'h01;
      end else if (eng_cmd.valid) begin
        if (cnt_q == (slow ? 5'h03 : 5'h00)) begin
          acc_q <= 1'b1;
          busy_q <= 1'b1;
          cnt_q <= slow ? 5'h14 : 5'h04;
        end else cnt_q <= cnt_q + 5'h01;
      end
    end
  end
  assign eng_status = {link_up, gen2, state, acc_q, done_q};
endmodule

// ### testbench.sv
// Self-checking bench for the link control block.
// Assumes dlc_eng_model stands in for the link training engine.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, arst_n = 1'b0, role = 1'b0, aut = 1'b0, spd = 1'b0, pref = 1'b0;
  logic src = 1'b0, send = 1'b0, part = 1'b0, l2 = 1'b0, lnk = 1'b1, gen2 = 1'b1, slow = 1'b0;
  logic [1:0] code = 2'h0, lanes = 2'h0;
  logic [5:0] state = 6'h00;
  logic done, hrx, deem, htx, lup, g2c;
  logic [5:0] lts;
  dlc_pkg::dlc_cmd_t cmd;
  dlc_pkg::dlc_eng_t st;
  int err_count = 0;
  int samples_checked = 0;
  dlc_link_ctrl u_dut (.clk, .arst_n, .role_rootport(role), .change_request_code(code),
    .target_speed_select(spd), .target_lane_count(lanes), .change_reason_autonomous(aut),
    .change_complete(done), .endpoint_deemphasis_pref(pref), .rootport_deemphasis_source(src),
    .inband_reset_send(send), .inband_reset_received(hrx), .link_up(lup),
    .second_gen_capable(g2c), .link_training_state(lts), .eng_status(st),
    .partner_deemph(part), .linkctl2_deemph(l2),
    .eng_cmd(cmd), .eng_tx_deemph(deem), .eng_hot_reset_tx(htx));
  dlc_eng_model u_eng (.clk, .arst_n, .eng_cmd(cmd), .link_up(lnk), .gen2, .slow, .state,
    .eng_status(st));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic final_report;
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic do_reset(input logic rp);
    @(posedge clk);
    arst_n <= 1'b0;
    role <= rp;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    tick(2);
  endtask
  // One directed change; ok says whether the block should pass it on
  task automatic do_change(input logic [1:0] c, input logic s, input logic [1:0] l,
      input logic a, input logic ok);
    int n;
    n = 0;
    @(posedge clk);
    code <= c;
    spd <= s;
    lanes <= l;
    aut <= a;
    tick(1);
    while (cmd.valid !== 1'b1 && n < 30) begin
      tick(1);
      n++;
    end
    chk(cmd.valid, ok, "command issue");
    if (ok) begin
      chk({cmd.do_width, cmd.do_speed, cmd.speed, cmd.lanes, cmd.autonomous},
        {c[0], c[1], s, l, a}, "command fields");
      n = 0;
      while (done !== 1'b1 && n < 60) begin
        tick(1);
        n++;
      end
      tick(3);
      chk(done, 1'b1, "completion");
    end
    @(posedge clk);
    code <= dlc_pkg::CHG_NONE;
    tick(2);
    chk(done, 1'b0, "completion clear");
  endtask
  task automatic t_changes;
    for (int i = 0; i < 4; i++) do_change(dlc_pkg::CHG_WIDTH, 1'b0, 2'(i), i[0], 1'b1);
    @(posedge clk);
    pref <= dlc_pkg::DEEMPH_3P5DB;
    do_change(dlc_pkg::CHG_SPEED, dlc_pkg::SPEED_5G0, 2'h0, 1'b0, 1'b1);
    chk(deem, dlc_pkg::DEEMPH_3P5DB, "deemphasis with speed up");
    @(posedge clk);
    slow <= 1'b1;
    do_change(dlc_pkg::CHG_BOTH, dlc_pkg::SPEED_5G0, dlc_pkg::LANES_X8, 1'b1, 1'b1);
    @(posedge clk);
    slow <= 1'b0;
    gen2 <= 1'b0;
    do_change(dlc_pkg::CHG_SPEED, dlc_pkg::SPEED_5G0, 2'h0, 1'b0, 1'b0);
    @(posedge clk);
    lnk <= 1'b0;
    do_change(dlc_pkg::CHG_WIDTH, 1'b0, 2'h1, 1'b0, 1'b0);
    chk({lup, g2c}, 2'h0, "status mirror low");
    @(posedge clk);
    lnk <= 1'b1;
    gen2 <= 1'b1;
    tick(2);
    chk({lup, g2c}, 2'h3, "status mirror high");
    $display("test changes done");
  endtask
  task automatic t_endpoint;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      pref <= i[0];
      send <= 1'b1;
      state <= i[0] ? dlc_pkg::LTS_HOT_RESET : 6'h11;
      tick(2);
      chk(deem, i[0], "endpoint deemphasis");
      chk(hrx, i[0], "hot reset received");
      chk(lts, state, "state mirror");
      chk(htx, 1'b0, "endpoint hot reset send");
    end
    $display("test endpoint done");
  endtask
  task automatic t_rootport;
    do_reset(1'b1);
    do_change(dlc_pkg::CHG_SPEED, dlc_pkg::SPEED_2G5, 2'h0, 1'b0, 1'b0);
    do_change(dlc_pkg::CHG_WIDTH, 1'b0, dlc_pkg::LANES_X2, 1'b0, 1'b1);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      src <= i[1];
      part <= i[0];
      l2 <= ~i[0];
      tick(2);
      chk(deem, i[1] ? !i[0] : i[0], "root port deemphasis");
    end
    @(posedge clk);
    state <= 6'h00;
    tick(2);
    chk(htx, 1'b1, "root port hot reset send");
    @(posedge clk);
    state <= dlc_pkg::LTS_HOT_RESET;
    tick(2);
    chk(hrx, 1'b0, "root port received low");
    @(posedge clk);
    send <= 1'b0;
    tick(2);
    chk(htx, 1'b0, "root port hot reset release");
    $display("test root port done");
  endtask
  initial begin
    do_reset(1'b0);
    t_changes();
    t_endpoint();
    t_rootport();
    final_report();
  end
  initial begin
    repeat (4000) @(posedge clk);
    err_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    final_report();
  end
endmodule
